// [common/aosc_pkg.sv]
// Purpose: types shared by the output stage control block
// Assumes: constants live in aosc_regs.svh
// Notes:   four stages, indexed as below
package aosc_pkg;

	// ****************************************************************
	// stage indexing and carriers
	// ****************************************************************
	typedef enum logic [1:0] {
		AOSC_HP_LEFT,
		AOSC_HP_RIGHT,
		AOSC_SPK_LEFT,
		AOSC_SPK_RIGHT
	} aosc_stage_t;

	// per-stage power sequencing state
	typedef enum logic [1:0] {
		AOSC_ST_OFF,
		AOSC_ST_RAMP,
		AOSC_ST_ON
	} aosc_pwr_t;

	// analog control outputs of one headphone pair
	typedef struct packed {
		logic [1:0] enable;
		logic [1:0] current_limit;
		logic [1:0] common_mode;
		logic       lineout_mode;
		logic [3:0] left_gain;
	} aosc_hp_ctl_t;

	// analog control outputs of the speaker pair
	typedef struct packed {
		logic [1:0] enable;
		logic [1:0] switching;
		logic [1:0] left_gain;
		logic [1:0] right_gain;
	} aosc_spk_ctl_t;

	// volume stage controls for one channel
	typedef struct packed {
		logic       dac_route;
		logic       amp_route;
		logic       mute;
		logic [6:0] level;
	} aosc_vol_ctl_t;

endpackage : aosc_pkg

// [common/aosc_regs.svh]
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: page 0 and page 1 share one 8-bit offset space, selected by a page bit
// Notes:   definitions only
`ifndef AOSC_REGS_SVH
`define AOSC_REGS_SVH

// ****************************************************************
// offsets (page 0)
// ****************************************************************
`define AOSC_P0_OVERTEMP      8'h03
`define AOSC_P0_PIN_SELECT    8'h39
`define AOSC_P0_SOFT_STEP     8'h3f
// ****************************************************************
// offsets (page 1)
// ****************************************************************
`define AOSC_P1_HP_POWER      8'h1f
`define AOSC_P1_SPK_POWER     8'h20
`define AOSC_P1_DAC_ROUTE     8'h23
`define AOSC_P1_LSPK_VOL      8'h26
`define AOSC_P1_RSPK_VOL      8'h27
`define AOSC_P1_LHP_GAIN      8'h28
`define AOSC_P1_LSPK_GAIN     8'h2a
`define AOSC_P1_RSPK_GAIN     8'h2b
`define AOSC_P1_HP_MODE       8'h2c
// ****************************************************************
// own control registers (page 0)
// ****************************************************************
`define AOSC_P0_PAGE_SEL      8'h00
`define AOSC_P0_SOFT_RESET    8'h01
`define AOSC_P0_STAGE_STATE   8'h04
`define AOSC_P0_VOL_STATE_L   8'h05
`define AOSC_P0_VOL_STATE_R   8'h06
// ****************************************************************
// field positions
// ****************************************************************
`define AOSC_BIT_LEFT_PWR     7
`define AOSC_BIT_RIGHT_PWR    6
`define AOSC_BIT_HP_SHUTDOWN  1
`define AOSC_BIT_FAULT        0
`define AOSC_BIT_OTP          1
`define AOSC_BIT_DAC_LEFT     6
`define AOSC_BIT_DAC_RIGHT    2
`define AOSC_BIT_VOL_ROUTE    7
`define AOSC_VOL_MUTE_CODE    7'h7f
`define AOSC_VOL_MIN_CODE     7'h75
`define AOSC_PIN_MODE_ON      2'h3
`define AOSC_LINEOUT_MODE     2'h3
`define AOSC_SOFT_RESET_KEY   8'h01
// ****************************************************************
// reset values
// ****************************************************************
`define AOSC_RST_VOL          8'h7f
`define AOSC_RST_ZERO         8'h00
// ****************************************************************
// timing: soft-step intervals and soft-start time
// ****************************************************************
`define AOSC_CLK_MHZ          100
`define AOSC_STEP_US_0        61
`define AOSC_STEP_US_1        122
`define AOSC_STEP_US_2        244
`define AOSC_SOFTSTART_US     50
`define AOSC_STEP_CYC_0       (`AOSC_STEP_US_0 * `AOSC_CLK_MHZ)
`define AOSC_STEP_CYC_1       (`AOSC_STEP_US_1 * `AOSC_CLK_MHZ)
`define AOSC_STEP_CYC_2       (`AOSC_STEP_US_2 * `AOSC_CLK_MHZ)
`define AOSC_SOFTSTART_CYC    (`AOSC_SOFTSTART_US * `AOSC_CLK_MHZ)

`endif

// [rtl/aosc_top.sv]
// Purpose: register bank and sequencing for playback output stages
// Assumes: one 100 MHz clock; fault and temperature inputs come from analog
// Notes:   registers reached by plain strobed port, read data one cycle later
//
// Notes on behaviour
// - dac route bit 6 feeds left volume stage, bit 2 feeds right stage
// - speaker volume 0 to -78 dB in half-dB steps plus mute, soft-stepped
// - left speaker volume in reg 38 bits 6-0, right in reg 39
// - bit 7 of regs 38/39 routes volume stage into speaker amplifier
// - volume stage mutes when route bit clear and code is 127
// - soft-step interval chosen by reg 63 bits 1-0
// - pattern 11 in reg 44 bits 2-1 selects low-power line-out drive
// - reg 31 bits 4-3 choose one of four common-mode levels
// - reg 31 bit 7 powers left headphone, bit 6 right headphone
// - left headphone gain from reg 40 bits 6-3
// - headphone short: bit 1 clear limits current, set shuts down
// - headphone short on either channel sets read-only flag bit 0
// - in shutdown mode a short clears that channel's power bit
// - setting power bit again restarts stage; recovers or shuts again
// - reset pin or software reset returns all registers to defaults
// - reg 32 bit 7 powers left speaker, bit 6 right speaker
// - speaker gains from bits 4-3 of regs 42 and 43
// - speaker overcurrent always shuts down and sets flag bit 0 of reg 32
// - setting speaker power bit again restarts stage after shutdown
// - overtemperature stops speaker switching, flagged in page 0 reg 3 bit 1
// - pin control only when page 0 reg 57 bits 2-1 are 11, off by default
// - under pin control low pin powers speakers, high powers headphones
// - under register control stages soft-start and may all be on at once
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "aosc_regs.svh"

module aosc_top
	import aosc_pkg::*;
#(
	parameter int STEP_CYC_0    = `AOSC_STEP_CYC_0,
	parameter int STEP_CYC_1    = `AOSC_STEP_CYC_1,
	parameter int STEP_CYC_2    = `AOSC_STEP_CYC_2,
	parameter int SOFTSTART_CYC = `AOSC_SOFTSTART_CYC
) (
	input  wire logic          clk_sys_i,
	input  wire logic          rst_n_i,
	input  wire logic [7:0]    addr_i,
	input  wire logic [7:0]    wdata_i,
	input  wire logic          wr_i,
	input  wire logic          rd_i,
	output logic      [7:0]    rdata_o,
	input  wire logic          output_stage_select_pin_i,
	input  wire logic [3:0]    short_i,
	input  wire logic          overtemp_i,
	output aosc_hp_ctl_t       hp_ctl_o,
	output aosc_spk_ctl_t      spk_ctl_o,
	output aosc_vol_ctl_t      vol_left_o,
	output aosc_vol_ctl_t      vol_right_o
);

	// ****************************************************************
	// input synchronisers
	// ****************************************************************
	logic [5:0] sync_a, sync_b, sync_c;
	logic [5:0] filt, next_filt;
	logic       soft_reset;

	// analog flags and the select pin are asynchronous to the clock
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync_a <= 6'h00;
			sync_b <= 6'h00;
			sync_c <= 6'h00;
			filt   <= 6'h00;
		end else begin
			sync_a <= {output_stage_select_pin_i, overtemp_i, short_i};
			sync_b <= sync_a;
			sync_c <= sync_b;
			filt   <= next_filt;
		end
	end

	// a change counts only when second and third stages agree
	always_comb begin
		next_filt = filt;
		for (int i = 0; i < 6; i++) begin
			if (sync_b[i] == sync_c[i])
				next_filt[i] = sync_b[i];
		end
	end

	wire logic [3:0] short_s = filt[3:0];
	wire logic       otp_s   = filt[4];
	wire logic       pin_s   = filt[5];

	// ****************************************************************
	// register file
	// ****************************************************************
	logic       page, next_page;
	logic [7:0] pin_sel, soft_step, hp_pwr, spk_pwr, route, lvol, rvol;
	logic [7:0] lhp_gain, lspk_gain, rspk_gain, hp_mode;
	logic [7:0] next_pin_sel, next_soft_step, next_hp_pwr, next_spk_pwr, next_route;
	logic [7:0] next_lvol, next_rvol, next_lhp_gain, next_lspk_gain, next_rspk_gain;
	logic [7:0] next_hp_mode;
	logic [3:0] trip, restart;
	logic       hp_fault, spk_fault, next_hp_fault, next_spk_fault;

	function automatic logic hit(input logic pg, input logic [7:0] off);
		hit = wr_i && (page == pg) && (addr_i == off);
	endfunction : hit

	// software reset is the key write only; the reset pin acts asynchronously
	assign soft_reset = hit(1'b0, `AOSC_P0_SOFT_RESET) && wdata_i == `AOSC_SOFT_RESET_KEY;

	// software writes, then hardware clears of power bits
	always_comb begin
		next_page      = page;
		next_pin_sel   = pin_sel;
		next_soft_step = soft_step;
		next_hp_pwr    = hp_pwr;
		next_spk_pwr   = spk_pwr;
		next_route     = route;
		next_lvol      = lvol;
		next_rvol      = rvol;
		next_lhp_gain  = lhp_gain;
		next_lspk_gain = lspk_gain;
		next_rspk_gain = rspk_gain;
		next_hp_mode   = hp_mode;
		next_hp_fault  = hp_fault;
		next_spk_fault = spk_fault;
		restart        = 4'h0;
		if (wr_i && addr_i == `AOSC_P0_PAGE_SEL) next_page = wdata_i[0];
		if (hit(1'b0, `AOSC_P0_PIN_SELECT)) next_pin_sel  = wdata_i;
		if (hit(1'b0, `AOSC_P0_SOFT_STEP)) next_soft_step = wdata_i;
		if (hit(1'b1, `AOSC_P1_HP_POWER)) begin
			// fault flag bit 0 is read-only
			next_hp_pwr = {wdata_i[7:1], 1'b0};
			restart[0]  = wdata_i[`AOSC_BIT_LEFT_PWR];
			restart[1]  = wdata_i[`AOSC_BIT_RIGHT_PWR];
		end
		if (hit(1'b1, `AOSC_P1_SPK_POWER)) begin
			next_spk_pwr = {wdata_i[7:1], 1'b0};
			restart[2]   = wdata_i[`AOSC_BIT_LEFT_PWR];
			restart[3]   = wdata_i[`AOSC_BIT_RIGHT_PWR];
		end
		if (hit(1'b1, `AOSC_P1_DAC_ROUTE)) next_route     = wdata_i;
		if (hit(1'b1, `AOSC_P1_LSPK_VOL))  next_lvol      = wdata_i;
		if (hit(1'b1, `AOSC_P1_RSPK_VOL))  next_rvol      = wdata_i;
		if (hit(1'b1, `AOSC_P1_LHP_GAIN))  next_lhp_gain  = wdata_i;
		if (hit(1'b1, `AOSC_P1_LSPK_GAIN)) next_lspk_gain = wdata_i;
		if (hit(1'b1, `AOSC_P1_RSPK_GAIN)) next_rspk_gain = wdata_i;
		if (hit(1'b1, `AOSC_P1_HP_MODE))   next_hp_mode   = wdata_i;
		// a same-cycle write that sets a power bit suppresses the trip, so the write wins
		if (trip[0]) next_hp_pwr[`AOSC_BIT_LEFT_PWR]   = 1'b0;
		if (trip[1]) next_hp_pwr[`AOSC_BIT_RIGHT_PWR]  = 1'b0;
		if (trip[2]) next_spk_pwr[`AOSC_BIT_LEFT_PWR]  = 1'b0;
		if (trip[3]) next_spk_pwr[`AOSC_BIT_RIGHT_PWR] = 1'b0;
		// flags hold while a short lasts, so a shutdown stays visible
		next_hp_fault  = |trip[1:0] | (|(short_s[1:0] & hp_en_mask()))
			| (hp_fault & |short_s[1:0]);
		next_spk_fault = |trip[3:2] | (|(short_s[3:2] & spk_en_mask()))
			| (spk_fault & |short_s[3:2]);
		if (soft_reset) begin
			next_page      = 1'b0;
			next_pin_sel   = `AOSC_RST_ZERO;
			next_soft_step = `AOSC_RST_ZERO;
			next_hp_pwr    = `AOSC_RST_ZERO;
			next_spk_pwr   = `AOSC_RST_ZERO;
			next_route     = `AOSC_RST_ZERO;
			next_lvol      = `AOSC_RST_VOL;
			next_rvol      = `AOSC_RST_VOL;
			next_lhp_gain  = `AOSC_RST_ZERO;
			next_lspk_gain = `AOSC_RST_ZERO;
			next_rspk_gain = `AOSC_RST_ZERO;
			next_hp_mode   = `AOSC_RST_ZERO;
			next_hp_fault  = 1'b0;
			next_spk_fault = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			page      <= 1'b0;
			pin_sel   <= `AOSC_RST_ZERO;
			soft_step <= `AOSC_RST_ZERO;
			hp_pwr    <= `AOSC_RST_ZERO;
			spk_pwr   <= `AOSC_RST_ZERO;
			route     <= `AOSC_RST_ZERO;
			lvol      <= `AOSC_RST_VOL;
			rvol      <= `AOSC_RST_VOL;
			lhp_gain  <= `AOSC_RST_ZERO;
			lspk_gain <= `AOSC_RST_ZERO;
			rspk_gain <= `AOSC_RST_ZERO;
			hp_mode   <= `AOSC_RST_ZERO;
			hp_fault  <= 1'b0;
			spk_fault <= 1'b0;
		end else begin
			page      <= next_page;
			pin_sel   <= next_pin_sel;
			soft_step <= next_soft_step;
			hp_pwr    <= next_hp_pwr;
			spk_pwr   <= next_spk_pwr;
			route     <= next_route;
			lvol      <= next_lvol;
			rvol      <= next_rvol;
			lhp_gain  <= next_lhp_gain;
			lspk_gain <= next_lspk_gain;
			rspk_gain <= next_rspk_gain;
			hp_mode   <= next_hp_mode;
			hp_fault  <= next_hp_fault;
			spk_fault <= next_spk_fault;
		end
	end

	// ****************************************************************
	// stage enables: register or pin control
	// ****************************************************************
	wire logic pin_mode = pin_sel[2:1] == `AOSC_PIN_MODE_ON;
	logic [3:0] want;

	// pin mode makes headphone and speaker pairs exclusive
	always_comb begin
		want = {spk_pwr[`AOSC_BIT_RIGHT_PWR], spk_pwr[`AOSC_BIT_LEFT_PWR],
			hp_pwr[`AOSC_BIT_RIGHT_PWR], hp_pwr[`AOSC_BIT_LEFT_PWR]};
		if (pin_mode)
			want = pin_s ? {2'b00, want[1:0]} : {want[3:2], 2'b00};
	end

	function automatic logic [1:0] hp_en_mask();
		hp_en_mask = want[1:0];
	endfunction : hp_en_mask

	function automatic logic [1:0] spk_en_mask();
		spk_en_mask = want[3:2];
	endfunction : spk_en_mask

	// ****************************************************************
	// per-stage soft-start sequencer
	// ****************************************************************
	aosc_pwr_t  pst [4];
	aosc_pwr_t  next_pst [4];
	logic [15:0] pcnt [4];
	logic [15:0] next_pcnt [4];
	logic [3:0] stage_on;

	generate
		for (genvar g = 0; g < 4; g++) begin : g_stage
			// headphone shuts only in shutdown mode; speakers always
			wire logic shut_mode = (g >= 2) ? 1'b1 : hp_pwr[`AOSC_BIT_HP_SHUTDOWN];
			assign trip[g] = (pst[g] != AOSC_ST_OFF) && short_s[g] && shut_mode && !restart[g];
			assign stage_on[g] = pst[g] == AOSC_ST_ON;

			always_comb begin
				next_pst[g]  = pst[g];
				next_pcnt[g] = pcnt[g];
				unique case (pst[g])
					AOSC_ST_OFF: if (want[g]) begin
						next_pst[g]  = AOSC_ST_RAMP;
						next_pcnt[g] = 16'h0000;
					end
					AOSC_ST_RAMP: begin
						next_pcnt[g] = pcnt[g] + 16'h0001;
						if (pcnt[g] == 16'(SOFTSTART_CYC - 1))
							next_pst[g] = AOSC_ST_ON;
					end
					AOSC_ST_ON: ;
				endcase
				if (!want[g] || trip[g] || soft_reset)
					next_pst[g] = AOSC_ST_OFF;
				if (restart[g] && want[g] && !soft_reset) begin
					next_pst[g]  = AOSC_ST_RAMP;
					next_pcnt[g] = 16'h0000;
				end
			end

			always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					pst[g]  <= AOSC_ST_OFF;
					pcnt[g] <= 16'h0000;
				end else begin
					pst[g]  <= next_pst[g];
					pcnt[g] <= next_pcnt[g];
				end
			end
		end
	endgenerate

	// ****************************************************************
	// soft-stepped speaker volume
	// ****************************************************************
	logic [6:0]  cur_vol [2];
	logic [6:0]  next_cur_vol [2];
	logic [17:0] step_cnt, next_step_cnt, step_len;
	logic        step_tick;

	// interval select; code 11 ticks every clock, so the level still steps one code per cycle
	always_comb begin
		unique case (soft_step[1:0])
			2'h0:    step_len = 18'(STEP_CYC_0 - 1);
			2'h1:    step_len = 18'(STEP_CYC_1 - 1);
			2'h2:    step_len = 18'(STEP_CYC_2 - 1);
			default: step_len = 18'h00000;
		endcase
		step_tick     = step_cnt >= step_len;
		next_step_cnt = step_tick ? 18'h00000 : step_cnt + 18'h00001;
	end

	generate
		for (genvar c = 0; c < 2; c++) begin : g_vol
			wire logic [6:0] tgt = (c == 0) ? lvol[6:0] : rvol[6:0];
			// codes above the floor all sit at the floor level
			wire logic [6:0] tgt_c = (tgt > `AOSC_VOL_MIN_CODE) ? `AOSC_VOL_MIN_CODE : tgt;
			always_comb begin
				next_cur_vol[c] = cur_vol[c];
				if (step_tick && cur_vol[c] < tgt_c)
					next_cur_vol[c] = cur_vol[c] + 7'h01;
				else if (step_tick && cur_vol[c] > tgt_c)
					next_cur_vol[c] = cur_vol[c] - 7'h01;
			end
			always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
				if (!rst_n_i)
					cur_vol[c] <= `AOSC_VOL_MIN_CODE;
				else
					cur_vol[c] <= next_cur_vol[c];
			end
		end
	endgenerate

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i)
			step_cnt <= 18'h00000;
		else
			step_cnt <= next_step_cnt;
	end

	// ****************************************************************
	// read mux and output registers
	// ****************************************************************
	logic [7:0] next_rdata;

	always_comb begin
		next_rdata = 8'h00;
		if (rd_i && page == 1'b0) begin
			unique case (addr_i)
				`AOSC_P0_PAGE_SEL:    next_rdata = {7'h00, page};
				`AOSC_P0_OVERTEMP:    next_rdata = {6'h00, otp_s, 1'b0};
				`AOSC_P0_PIN_SELECT:  next_rdata = pin_sel;
				`AOSC_P0_SOFT_STEP:   next_rdata = soft_step;
				`AOSC_P0_STAGE_STATE: next_rdata = {4'h0, stage_on};
				`AOSC_P0_VOL_STATE_L: next_rdata = {1'b0, cur_vol[0]};
				`AOSC_P0_VOL_STATE_R: next_rdata = {1'b0, cur_vol[1]};
				default:              next_rdata = 8'h00;
			endcase
		end else if (rd_i) begin
			unique case (addr_i)
				`AOSC_P1_HP_POWER:  next_rdata = {hp_pwr[7:1], hp_fault};
				`AOSC_P1_SPK_POWER: next_rdata = {spk_pwr[7:1], spk_fault};
				`AOSC_P1_DAC_ROUTE: next_rdata = route;
				`AOSC_P1_LSPK_VOL:  next_rdata = lvol;
				`AOSC_P1_RSPK_VOL:  next_rdata = rvol;
				`AOSC_P1_LHP_GAIN:  next_rdata = lhp_gain;
				`AOSC_P1_LSPK_GAIN: next_rdata = lspk_gain;
				`AOSC_P1_RSPK_GAIN: next_rdata = rspk_gain;
				`AOSC_P1_HP_MODE:   next_rdata = hp_mode;
				default:            next_rdata = 8'h00;
			endcase
		end
	end

	// analog controls registered so outputs come from flip-flops
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o     <= 8'h00;
			hp_ctl_o    <= '0;
			spk_ctl_o   <= '0;
			vol_left_o  <= '0;
			vol_right_o <= '0;
		end else begin
			rdata_o                 <= next_rdata;
			hp_ctl_o.enable         <= {pst[1] != AOSC_ST_OFF, pst[0] != AOSC_ST_OFF};
			hp_ctl_o.current_limit  <= {2{~hp_pwr[`AOSC_BIT_HP_SHUTDOWN]}} & short_s[1:0];
			hp_ctl_o.common_mode    <= hp_pwr[4:3];
			hp_ctl_o.lineout_mode   <= hp_mode[2:1] == `AOSC_LINEOUT_MODE;
			hp_ctl_o.left_gain      <= lhp_gain[6:3];
			spk_ctl_o.enable        <= {pst[3] != AOSC_ST_OFF, pst[2] != AOSC_ST_OFF};
			spk_ctl_o.switching     <= stage_on[3:2] & {2{~otp_s}};
			spk_ctl_o.left_gain     <= lspk_gain[4:3];
			spk_ctl_o.right_gain    <= rspk_gain[4:3];
			vol_left_o.dac_route    <= route[`AOSC_BIT_DAC_LEFT];
			vol_left_o.amp_route    <= lvol[`AOSC_BIT_VOL_ROUTE];
			vol_left_o.mute         <= !lvol[7] && lvol[6:0] == `AOSC_VOL_MUTE_CODE;
			vol_left_o.level        <= cur_vol[0];
			vol_right_o.dac_route   <= route[`AOSC_BIT_DAC_RIGHT];
			vol_right_o.amp_route   <= rvol[`AOSC_BIT_VOL_ROUTE];
			vol_right_o.mute        <= !rvol[7] && rvol[6:0] == `AOSC_VOL_MUTE_CODE;
			vol_right_o.level       <= cur_vol[1];
		end
	end

endmodule : aosc_top

// [test/aosc_load_model.sv]
// Purpose: analog side of the output stages: loads, die sensor, select pin
// Assumes: faults are ordered by the bench, never invented here
// Notes:   levels follow requests directly, as real comparators would
`timescale 1ns/1ps

module aosc_load_model (
	input  wire logic       fault_req_i,
	input  wire logic [3:0] short_req_i,
	input  wire logic       hot_req_i,
	input  wire logic       sel_req_i,
	output logic      [3:0] short_o,
	output logic            overtemp_o,
	output logic            select_o
);
	// ****************************************************************
	// load and sensor levels
	// ****************************************************************
	// a short exists only while faults are enabled, so a stray request stays harmless
	assign short_o    = fault_req_i ? short_req_i : 4'h0;
	assign overtemp_o = hot_req_i;
	assign select_o   = sel_req_i;
endmodule : aosc_load_model

// [test/aosc_top_asserts.sv]
// Purpose: port checker for the output stage control block
// Assumes: one clock domain, async active-low reset, tiny soft-start count
// Notes:   tracks page and pin mode from the register writes it sees
`timescale 1ns/1ps
`include "aosc_regs.svh"

module aosc_top_asserts
	import aosc_pkg::*;
#(
	parameter int SOFTSTART_CYC = 4
) (
	input wire logic          clk_sys_i,
	input wire logic          rst_n_i,
	input wire logic [7:0]    addr_i,
	input wire logic [7:0]    wdata_i,
	input wire logic          wr_i,
	input wire logic          rd_i,
	input wire logic [7:0]    rdata_o,
	input wire logic          output_stage_select_pin_i,
	input wire logic [3:0]    short_i,
	input wire logic          overtemp_i,
	input wire aosc_hp_ctl_t  hp_ctl_o,
	input wire aosc_spk_ctl_t spk_ctl_o,
	input wire aosc_vol_ctl_t vol_left_o,
	input wire aosc_vol_ctl_t vol_right_o
);
	// ****************************************************************
	// shadow state and properties
	// ****************************************************************
	localparam int SS_MAX = 12;
	logic page, pin_mode, live, next_page, next_pin;

	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	// shadow of page and pin mode; software reset clears both
	always_comb begin
		next_page = page;
		next_pin  = pin_mode;
		if (wr_i && addr_i == `AOSC_P0_PAGE_SEL) next_page = wdata_i[0];
		if (wr_i && !page && addr_i == `AOSC_P0_PIN_SELECT)
			next_pin = (wdata_i[2:1] == `AOSC_PIN_MODE_ON);
		if (wr_i && !page && addr_i == `AOSC_P0_SOFT_RESET && wdata_i == `AOSC_SOFT_RESET_KEY) begin
			next_page = 1'b0;
			next_pin  = 1'b0;
		end
	end

	// live masks the jump of the level output at the first edge
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			page     <= 1'b0;
			pin_mode <= 1'b0;
			live     <= 1'b0;
		end else begin
			page     <= next_page;
			pin_mode <= next_pin;
			live     <= 1'b1;
		end
	end

	rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data not zero outside its slot");
	unmapped_rd_a: assert property (rd_i && addr_i == 8'h02 |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	otp_stop_a: assert property (overtemp_i [*8] |-> spk_ctl_o.switching == 2'b00)
		else $error("speaker switching while hot");
	soft_start_a: assert property ($rose(spk_ctl_o.enable[0]) && !overtemp_i |->
		(!spk_ctl_o.switching[0]) [*3] ##[1:SS_MAX]
		(spk_ctl_o.switching[0] || !spk_ctl_o.enable[0] || overtemp_i))
		else $error("speaker soft start wrong");
	spk_trip_a: assert property ((short_i[2] && !wr_i) [*8] |->
		!spk_ctl_o.enable[0]) else $error("speaker stays on with short");
	pin_excl_a: assert property (pin_mode [*4] |->
		!((|hp_ctl_o.enable) && (|spk_ctl_o.enable))) else $error("both pairs on under pin");
	mute_code_a: assert property (wr_i && page && addr_i == 8'h27 && wdata_i == 8'h7f |=>
		##1 vol_right_o.mute) else $error("mute code not muting");
	vol_step_a: assert property (live && $past(live) && $changed(vol_left_o.level) |->
		vol_left_o.level == $past(vol_left_o.level) + 7'h01 ||
		vol_left_o.level == $past(vol_left_o.level) - 7'h01) else $error("volume jumped");

	cover property ($fell(spk_ctl_o.enable[0]));
	cover property (pin_mode && (|hp_ctl_o.enable));
	cover property ($rose(spk_ctl_o.switching[0]));
endmodule : aosc_top_asserts

bind aosc_top aosc_top_asserts #(.SOFTSTART_CYC(SOFTSTART_CYC)) u_chk (
	.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.output_stage_select_pin_i(output_stage_select_pin_i), .short_i(short_i),
	.overtemp_i(overtemp_i), .hp_ctl_o(hp_ctl_o), .spk_ctl_o(spk_ctl_o),
	.vol_left_o(vol_left_o), .vol_right_o(vol_right_o)
);

// [test/tb_audio_output_stage_control.sv]
// Purpose: self-checking bench for the output stage control block
// Assumes: short counts set by parameters, one gap cycle after each access
// Notes:   expected values come from the register map and field positions
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_total++; \
	$display("ERROR %s expected %h seen %h", nm, ex, got); end end

module tb_audio_output_stage_control
	import aosc_pkg::*;
;
	// ****************************************************************
	// signals, clock, tasks and scenarios
	// ****************************************************************
	logic clk_sys_i = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic [3:0] short_req = 4'h0, short_w;
	logic hot_req = 1'b0, sel_req = 1'b0, hot_w, sel_w;
	int err_total = 0, n_checks = 0, cyc = 0;
	aosc_hp_ctl_t hp;
	aosc_spk_ctl_t spk;
	aosc_vol_ctl_t vl, vr;

	aosc_load_model u_load (.fault_req_i(1'b1), .short_req_i(short_req), .hot_req_i(hot_req),
		.sel_req_i(sel_req), .short_o(short_w), .overtemp_o(hot_w), .select_o(sel_w));
	aosc_top #(.STEP_CYC_0(2), .STEP_CYC_1(3), .STEP_CYC_2(4), .SOFTSTART_CYC(4)) uut (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s),
		.rd_i(rd_s), .rdata_o(rdata), .output_stage_select_pin_i(sel_w), .short_i(short_w),
		.overtemp_i(hot_w), .hp_ctl_o(hp), .spk_ctl_o(spk), .vol_left_o(vl), .vol_right_o(vr));

	initial begin
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr  <= a;
		wdata <= d;
		wr_s  <= 1'b1;
		@(posedge clk_sys_i);
		wr_s  <= 1'b0;
		@(posedge clk_sys_i);
	endtask : wr

	// read data stand only in the cycle after the strobe, so look there
	task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] ex);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk_sys_i);
		rd_s <= 1'b0;
		#1;
		`CHK(nm, ex, rdata)
		@(posedge clk_sys_i);
	endtask : rd

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : wait_cyc

	task automatic t_fields();
		wr(8'h3f, 8'h02);
		wr(8'h00, 8'h01);
		wr(8'h23, 8'h44);
		wr(8'h26, 8'h85);
		wr(8'h27, 8'h7f);
		wr(8'h28, 8'h50);
		wr(8'h2a, 8'h18);
		wr(8'h2c, 8'h06);
		wait_cyc(140);
		`CHK("slow step", 1'b0, vl.level == 7'h05)
		wait_cyc(450);
		`CHK("left level", 7'h05, vl.level)
		`CHK("dac route", 2'b11, {vl.dac_route, vr.dac_route})
		`CHK("amp route", 2'b10, {vl.amp_route, vr.amp_route})
		`CHK("mute", 2'b01, {vl.mute, vr.mute})
		`CHK("hp gain", 4'ha, hp.left_gain)
		`CHK("spk gain", 2'h3, spk.left_gain)
		`CHK("line out", 1'b1, hp.lineout_mode)
		for (int i = 0; i < 4; i++) begin
			wr(8'h1f, 8'(i << 3));
			#1;
			`CHK("common mode", 2'(i), hp.common_mode)
		end
		$display("fields done");
	endtask : t_fields

	task automatic t_spk_short();
		wr(8'h20, 8'hc0);
		wait_cyc(1);
		`CHK("spk on", 2'b11, spk.enable)
		wait_cyc(8);
		`CHK("switching", 2'b11, spk.switching)
		short_req <= 4'h4;
		wait_cyc(10);
		rd("spk trip", 8'h20, 8'h41);
		wr(8'h20, 8'hc0);
		wait_cyc(4);
		rd("spk trip again", 8'h20, 8'h41);
		short_req <= 4'h0;
		wait_cyc(10);
		wr(8'h20, 8'hc1);
		rd("spk back", 8'h20, 8'hc0);
		$display("speaker short done");
	endtask : t_spk_short

	task automatic t_hp_short();
		wr(8'h1f, 8'hc0);
		short_req <= 4'h1;
		wait_cyc(10);
		rd("hp limit", 8'h1f, 8'hc1);
		`CHK("hp clamp", 2'b01, hp.current_limit)
		wr(8'h1f, 8'hc2);
		wait_cyc(10);
		rd("hp trip", 8'h1f, 8'h43);
		short_req <= 4'h0;
		wait_cyc(10);
		wr(8'h1f, 8'hc3);
		rd("hp back", 8'h1f, 8'hc2);
		$display("headphone short done");
	endtask : t_hp_short

	task automatic t_otp_pin();
		hot_req <= 1'b1;
		wait_cyc(10);
		wr(8'h00, 8'h00);
		rd("otp flag", 8'h03, 8'h02);
		`CHK("otp stop", 2'b00, spk.switching)
		hot_req <= 1'b0;
		wait_cyc(14);
		`CHK("otp resume", 2'b11, spk.switching)
		rd("otp clear", 8'h03, 8'h00);
		wr(8'h39, 8'h06);
		sel_req <= 1'b1;
		wait_cyc(10);
		`CHK("pin hp", 4'b1100, {hp.enable, spk.enable})
		sel_req <= 1'b0;
		wait_cyc(10);
		`CHK("pin spk", 4'b0011, {hp.enable, spk.enable})
		wr(8'h39, 8'h04);
		wait_cyc(4);
		`CHK("all on", 4'b1111, {hp.enable, spk.enable})
		$display("thermal and pin done");
	endtask : t_otp_pin

	task automatic t_resets();
		wr(8'h01, 8'h01);
		rd("sw pin sel", 8'h39, 8'h00);
		wr(8'h00, 8'h01);
		rd("sw spk", 8'h20, 8'h00);
		wr(8'h26, 8'h10);
		rst_n <= 1'b0;
		wait_cyc(2);
		rst_n <= 1'b1;
		@(posedge clk_sys_i);
		rd("unmapped", 8'h02, 8'h00);
		rd("pin default", 8'h39, 8'h00);
		rd("step default", 8'h3f, 8'h00);
		wr(8'h00, 8'h01);
		rd("hp default", 8'h1f, 8'h00);
		rd("left vol", 8'h26, 8'h7f);
		rd("right vol", 8'h27, 8'h7f);
		$display("resets done");
	endtask : t_resets

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict

	// hang guard well above the roughly 800 cycles the run needs
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			give_verdict();
		end
	end

	initial begin
		repeat (2) @(posedge clk_sys_i);
		rst_n <= 1'b1;
		@(posedge clk_sys_i);
		t_fields();
		t_spk_short();
		t_hp_short();
		t_otp_pin();
		t_resets();
		give_verdict();
	end
endmodule : tb_audio_output_stage_control
